// File: acc_unary_unit.sv
// Purpose: Accumulator-only, shift/rotate and arithmetic operations
// Assumes: Combinational, driven from the core
// Notes: Result applies at the next clock in the core
`timescale 1ns/10ps
`default_nettype none
module acc_unary_unit (
	// Operation path
	alu_if.unit a
);
	logic [15:0] v;
	logic [16:0] sum;
	logic [15:0] lo;
	logic cin15;
	always_comb begin
		v = a.din.acc;
		a.dout = '0;
		a.dout.res = v;
		a.dout.c_out = a.din.c_in;
		sum = 17'h00000;
		lo = 16'h0000;
		cin15 = 1'b0;
		case (a.op)
		core_pkg::OP_CPL: begin
			a.dout.res = ~v; // RULE3
			a.dout.acc_wr = 1'b1;
		end
		core_pkg::OP_NEG: begin
			a.dout.res = ~v + 16'h0001; // RULE3
			a.dout.acc_wr = 1'b1;
		end
		core_pkg::OP_RL: begin
			a.dout.res = {v[14:0], v[15]}; // RULE4
			a.dout.acc_wr = 1'b1;
		end
		core_pkg::OP_RR: begin
			a.dout.res = {v[0], v[15:1]}; // RULE4
			a.dout.acc_wr = 1'b1;
		end
		core_pkg::OP_RLC: begin
			{a.dout.c_out, a.dout.res} = {v, a.din.c_in}; // RULE4
			a.dout.c_wr = 1'b1;
			a.dout.acc_wr = 1'b1;
		end
		core_pkg::OP_RRC: begin
			{a.dout.res, a.dout.c_out} = {a.din.c_in, v}; // RULE4
			a.dout.c_wr = 1'b1;
			a.dout.acc_wr = 1'b1;
		end
		core_pkg::OP_SLA, core_pkg::OP_ARITH_SHIFT_LEFT_TWO, core_pkg::OP_ARITH_SHIFT_LEFT_FOUR: begin
			// Zeros enter at bit 0; last bit out of bit 15 lands in Carry
			if (a.op == core_pkg::OP_SLA)
				{a.dout.c_out, a.dout.res} = {v, 1'b0}; // RULE5 RULE24
			else if (a.op == core_pkg::OP_ARITH_SHIFT_LEFT_TWO)
				{a.dout.c_out, a.dout.res} = {v[14:0], 2'b00}; // RULE5 RULE24
			else
				{a.dout.c_out, a.dout.res} = {v[12:0], 4'h0}; // RULE5 RULE24
			a.dout.c_wr = 1'b1;
			a.dout.acc_wr = 1'b1;
		end
		core_pkg::OP_SRA: begin
			a.dout.res = {v[15], v[15:1]}; // RULE6
			a.dout.c_out = v[0];
			a.dout.c_wr = 1'b1;
			a.dout.acc_wr = 1'b1;
		end
		core_pkg::OP_ARITH_SHIFT_RIGHT_TWO: begin
			a.dout.res = {{2{v[15]}}, v[15:2]}; // RULE6
			a.dout.c_out = v[1];
			a.dout.c_wr = 1'b1;
			a.dout.acc_wr = 1'b1;
		end
		core_pkg::OP_ARITH_SHIFT_RIGHT_FOUR: begin
			a.dout.res = {{4{v[15]}}, v[15:4]}; // RULE6
			a.dout.c_out = v[3];
			a.dout.c_wr = 1'b1;
			a.dout.acc_wr = 1'b1;
		end
		core_pkg::OP_SR: begin
			a.dout.res = {1'b0, v[15:1]}; // RULE7
			a.dout.c_out = v[0];
			a.dout.c_wr = 1'b1;
			a.dout.acc_wr = 1'b1;
		end
		core_pkg::OP_XCHN: begin
			a.dout.res = {v[11:8], v[15:12], v[3:0], v[7:4]}; // RULE8
			a.dout.acc_wr = 1'b1;
		end
		core_pkg::OP_XCH: begin
			a.dout.res = {v[7:0], v[15:8]}; // RULE8
			a.dout.acc_wr = 1'b1;
		end
		core_pkg::OP_ADD, core_pkg::OP_ADDC,
		core_pkg::OP_SUB, core_pkg::OP_SUBB: begin
			// Subtract as add of inverse; Carry then means borrow
			if (a.op == core_pkg::OP_ADD || a.op == core_pkg::OP_ADDC) begin
				sum = {1'b0, v} + {1'b0, a.src} +
					{16'h0000, a.op == core_pkg::OP_ADDC && a.din.c_in};
				lo = {1'b0, v[14:0]} + {1'b0, a.src[14:0]} +
					{15'h0000, a.op == core_pkg::OP_ADDC && a.din.c_in};
				a.dout.c_out = sum[16]; // RULE15
			end else begin
				sum = {1'b0, v} + {1'b0, ~a.src} +
					{16'h0000, !(a.op == core_pkg::OP_SUBB && a.din.c_in)};
				lo = {1'b0, v[14:0]} + {1'b0, ~a.src[14:0]} +
					{15'h0000, !(a.op == core_pkg::OP_SUBB && a.din.c_in)};
				a.dout.c_out = !sum[16]; // RULE15
			end
			cin15 = lo[15];
			a.dout.res = sum[15:0];
			a.dout.ov = sum[16] ^ cin15; // RULE16
			a.dout.ov_wr = 1'b1;
			a.dout.c_wr = 1'b1;
			a.dout.acc_wr = 1'b1;
		end
		default: begin
			a.dout.res = v;
		end
		endcase
		// Every accumulator-writing operation here takes a pointer step
		a.dout.step = a.dout.acc_wr; // RULE2
	end
endmodule
`default_nettype wire

// File: accum_core.sv
// Purpose: Accumulator datapath, flag word and program flow of the core
// Assumes: APB master issues instructions by register writes
// Notes: Stack lives inside as a small register file
//
// What this block does
// (RULE1) Active accumulator is the one indexed by pointer low four bits.
// (RULE2) Auto-step the pointer after unary and arithmetic/logic operations.
// (RULE3) Complement inverts all bits; negate is inverse plus one.
// (RULE4) Rotate left/right by one, plain or through Carry.
// (RULE5) Arithmetic left shifts by one, two, four update Carry.
// (RULE6) Sign-preserving right shifts by one, two, four update Carry.
// (RULE7) Logical right shift: bit 0 to Carry, top bit cleared.
// (RULE8) Nibble swap within each byte; byte swap of the word.
// (RULE9) Bit ops: bit to Carry, Carry to bit, AND/OR/XOR into Carry.
// (RULE10) Bit operations never step the accumulator pointer.
// (RULE11) Sign flag bit 6 mirrors active accumulator top bit.
// (RULE12) Zero flag bit 7 is one when active accumulator is zero.
// (RULE13) Equals flag bit 0 is stored; compare sets or clears it.
// (RULE14) Writing the flag word can change stored Equals and Carry.
// (RULE15) Carry holds add/subtract carry; set, clear, complement allowed.
// (RULE16) Overflow bit 2 updated only by add/subtract family.
// (RULE17) Reading the instruction pointer returns current address plus one.
// (RULE18) Relative jump uses signed 8-bit word offset.
// (RULE19) Absolute jump: 16-bit immediate/register, or prefix plus 8-bit.
// (RULE20) Conditional jumps branch only when the flag condition holds.
// (RULE21) Equals-conditioned jumps accept immediate targets only.
// (RULE22) Call pushes next address, then branches like a jump.
// (RULE23) Return pops the resume address; separate interrupt return.
// (RULE24) Left shifts bring in zeros; last bit out goes to Carry.
`timescale 1ns/10ps
`default_nettype none
`include "core_defines.svh"
module accum_core (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core state seen outside
	output logic [15:0] instruction_pointer,
	output logic [7:0] processor_flag_word,
	output logic in_service
);
	localparam int DEPTH = 8;
	typedef struct packed {
		logic [15:0][15:0] acc;
		logic [3:0] accum_select_ptr;
		logic [7:0] accum_step_control;
		logic [15:0] ip;
		logic c;
		logic e;
		logic ov;
		logic [15:0] operand;
		logic [7:0] prefix;
		logic [DEPTH-1:0][15:0] stack;
		logic [2:0] sp;
		logic isr;
		logic bad;
		logic [31:0] rdata;
	} state_t;
	state_t s_reg, s_next;
	alu_if au ();
	logic wr_en, rd_en, taken, bad_instr;
	logic [15:0] act, target, nxt;
	logic [3:0] stepped, mask;
	core_pkg::op_t op;
	core_pkg::cond_t cnd;
	logic [3:0] bitno;
	logic [7:0] flags;
	acc_unary_unit unit (
		.a(au.unit)
	);
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign act = s_reg.acc[s_reg.accum_select_ptr]; // RULE1
	// Sign and Zero are live views, never stored
	assign flags = {act == 16'h0000, act[15], 3'b000, // RULE11 RULE12
		s_reg.ov, s_reg.c, s_reg.e};
	assign op = core_pkg::op_t'(pwdata[5:0]);
	assign cnd = core_pkg::cond_t'(pwdata[10:8]);
	assign bitno = pwdata[19:16];
	assign au.op = op;
	// One driver for the whole operand struct
	assign au.din = {act, s_reg.c, 1'b0, bitno};
	assign au.src = s_reg.operand;
	assign nxt = s_reg.ip + 16'h0001;
	// ----------------------------------------------------------------
	// Pointer stepping
	// ----------------------------------------------------------------
	always_comb begin
		case (s_reg.accum_step_control[2:0])
		3'b001: mask = 4'h1;
		3'b010: mask = 4'h3;
		3'b011: mask = 4'h7;
		3'b100: mask = 4'hf;
		default: mask = 4'h0;
		endcase
		if (s_reg.accum_step_control[`STEP_IDS])
			stepped = s_reg.accum_select_ptr - 4'h1;
		else
			stepped = s_reg.accum_select_ptr + 4'h1;
		// Wrap inside the selected field only
		stepped = (stepped & mask) | (s_reg.accum_select_ptr & ~mask);
	end
	// ----------------------------------------------------------------
	// Branch condition and target
	// ----------------------------------------------------------------
	always_comb begin
		case (cnd)
		core_pkg::CND_C: taken = s_reg.c; // RULE20
		core_pkg::CND_NC: taken = !s_reg.c;
		core_pkg::CND_Z: taken = flags[`FLG_Z];
		core_pkg::CND_NZ: taken = !flags[`FLG_Z];
		core_pkg::CND_S: taken = flags[`FLG_S];
		core_pkg::CND_E: taken = s_reg.e;
		core_pkg::CND_NE: taken = !s_reg.e;
		default: taken = 1'b1;
		endcase
		case (op)
		core_pkg::OP_JREL, core_pkg::OP_CALLREL:
			target = nxt + {{8{s_reg.operand[7]}}, s_reg.operand[7:0]}; // RULE18
		core_pkg::OP_JREG8:
			target = {s_reg.prefix, s_reg.operand[7:0]}; // RULE19
		default:
			target = s_reg.operand; // RULE19
		endcase
		// Equals conditions refuse register targets
		bad_instr = (cnd == core_pkg::CND_E || cnd == core_pkg::CND_NE) &&
			(op == core_pkg::OP_JREG16 || op == core_pkg::OP_JREG8 ||
			op == core_pkg::OP_CALLREG); // RULE21
	end
	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		if (wr_en) begin
			case (paddr)
			`OFS_OPERAND: s_next.operand = pwdata[15:0];
			`OFS_PTR: s_next.accum_select_ptr = pwdata[3:0];
			`OFS_STEP: s_next.accum_step_control = pwdata[7:0];
			`OFS_PREFIX: s_next.prefix = pwdata[7:0];
			`OFS_ACC: s_next.acc[s_reg.accum_select_ptr] = pwdata[15:0];
			`OFS_IPTR: s_next.ip = pwdata[15:0];
			`OFS_FLAGS: begin
				s_next.e = pwdata[`FLG_E]; // RULE14
				s_next.c = pwdata[`FLG_C]; // RULE14
				// Overflow belongs to the add/subtract family alone
			end
			`OFS_INSTR: begin
				s_next.bad = 1'b0;
				s_next.ip = nxt;
				case (op)
				core_pkg::OP_BIT2C: s_next.c = act[bitno]; // RULE9 RULE10
				core_pkg::OP_C2BIT:
					s_next.acc[s_reg.accum_select_ptr][bitno] = s_reg.c; // RULE9
				core_pkg::OP_BAND: s_next.c = s_reg.c & act[bitno]; // RULE9
				core_pkg::OP_BOR: s_next.c = s_reg.c | act[bitno]; // RULE9
				core_pkg::OP_BXOR: s_next.c = s_reg.c ^ act[bitno]; // RULE9
				core_pkg::OP_SETC: s_next.c = 1'b1; // RULE15
				core_pkg::OP_CLRC: s_next.c = 1'b0; // RULE15
				core_pkg::OP_CPLC: s_next.c = !s_reg.c; // RULE15
				core_pkg::OP_CMP: s_next.e = (s_reg.operand == act); // RULE13
				core_pkg::OP_WRFLAGS: begin
					s_next.e = s_reg.operand[`FLG_E]; // RULE14
					s_next.c = s_reg.operand[`FLG_C]; // RULE14 RULE16
				end
				core_pkg::OP_JREL, core_pkg::OP_JIMM, core_pkg::OP_JREG16,
				core_pkg::OP_JREG8: begin
					if (bad_instr)
						s_next.bad = 1'b1;
					else if (taken)
						s_next.ip = target; // RULE20
				end
				core_pkg::OP_CALLREL, core_pkg::OP_CALLIMM,
				core_pkg::OP_CALLREG: begin
					if (bad_instr) begin
						s_next.bad = 1'b1;
					end else if (taken) begin
						s_next.stack[s_reg.sp] = nxt; // RULE22
						s_next.sp = s_reg.sp + 3'd1;
						s_next.ip = target; // RULE22
					end
				end
				core_pkg::OP_RET, core_pkg::OP_RETI: begin
					s_next.sp = s_reg.sp - 3'd1;
					s_next.ip = s_reg.stack[s_reg.sp - 3'd1]; // RULE23
					if (op == core_pkg::OP_RETI)
						s_next.isr = 1'b0; // RULE23
				end
				default: begin
					if (au.dout.acc_wr)
						s_next.acc[s_reg.accum_select_ptr] = au.dout.res; // RULE3
					if (au.dout.c_wr)
						s_next.c = au.dout.c_out; // RULE15
					if (au.dout.ov_wr)
						s_next.ov = au.dout.ov; // RULE16
					if (au.dout.step)
						s_next.accum_select_ptr = stepped; // RULE2
				end
				endcase
			end
			default: begin
			end
			endcase
		end
		s_next.rdata = 32'h0000_0000;
		if (rd_en) begin
			case (paddr)
			`OFS_INSTR: s_next.rdata = s_reg.bad ? `INSTR_BAD : `INSTR_OK;
			`OFS_OPERAND: s_next.rdata = {16'h0000, s_reg.operand};
			`OFS_FLAGS: s_next.rdata = {24'h000000, flags};
			`OFS_PTR: s_next.rdata = {28'h0000000, s_reg.accum_select_ptr};
			`OFS_STEP: s_next.rdata = {24'h000000, s_reg.accum_step_control};
			`OFS_IPTR: s_next.rdata = {16'h0000, nxt}; // RULE17
			`OFS_ACC: s_next.rdata = {16'h0000, act};
			`OFS_STACK: s_next.rdata = {29'h00000000, s_reg.sp};
			`OFS_PREFIX: s_next.rdata = {24'h000000, s_reg.prefix};
			default: s_next.rdata = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.accum_select_ptr <= `PTR_RST;
			s_reg.accum_step_control <= `STEP_RST;
			s_reg.ip <= `IP_RST;
		end else begin
			s_reg <= s_next;
		end
	end
	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Read data is combinational from state so the answer needs no wait
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_en) begin
			prdata = s_next.rdata;
		end
	end
	assign pready = 1'b1;
	assign pslverr = psel && penable && !(paddr == `OFS_INSTR ||
		paddr == `OFS_OPERAND || paddr == `OFS_FLAGS || paddr == `OFS_PTR ||
		paddr == `OFS_STEP || paddr == `OFS_IPTR || paddr == `OFS_ACC ||
		paddr == `OFS_STACK || paddr == `OFS_PREFIX);
	assign instruction_pointer = s_reg.ip;
	assign processor_flag_word = flags;
	assign in_service = s_reg.isr;
endmodule
`default_nettype wire

// File: accum_core_sva.sv
// Purpose: Port-level checks of the accumulator core
// Assumes: Zero-wait APB slave, map from the core defines
// Notes: Sees only the top module ports; bound at the foot
`timescale 1ns/10ps
`default_nettype none
`include "core_defines.svh"
module accum_core_sva (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Core state
	input wire logic [15:0] instruction_pointer,
	input wire logic [7:0] processor_flag_word,
	input wire logic in_service
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc, rd, wr_ins, wr_flg, ov_src, eq_src, ip_src;
	assign acc = psel && penable;
	assign rd = acc && !pwrite;
	assign wr_ins = acc && pwrite && paddr == `OFS_INSTR;
	assign wr_flg = acc && pwrite && paddr == `OFS_FLAGS;
	// Only add, add-carry, sub and sub-borrow (0x18..0x1b) may move OV
	assign ov_src = wr_ins && pwdata[5:2] == 4'b0110;
	// Compare, flag-word instruction or a flag-word register write
	assign eq_src = (wr_ins && (pwdata[5:0] == 6'h1c ||
		pwdata[5:0] == 6'h1d)) || wr_flg;
	assign ip_src = wr_ins || (acc && pwrite && paddr == `OFS_IPTR);
	property p_ready; acc |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("no ready");
	property p_idle; !acc |-> prdata == 32'h0 && !pslverr; endproperty
	a_idle: assert property (p_idle) else $error("bus not quiet");
	property p_iprd;
		rd && paddr == `OFS_IPTR |->
			prdata == {16'h0, instruction_pointer + 16'h1};
	endproperty
	a_iprd: assert property (p_iprd) else $error("ip read");
	property p_sign;
		rd && paddr == `OFS_ACC |-> prdata[15] == processor_flag_word[6];
	endproperty
	a_sign: assert property (p_sign) else $error("sign flag");
	property p_zero;
		rd && paddr == `OFS_ACC |->
			(prdata[15:0] == 16'h0) == processor_flag_word[7];
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag");
	property p_ov; $changed(processor_flag_word[2]) |-> $past(ov_src);
	endproperty
	a_ov: assert property (p_ov) else $error("ov moved");
	property p_eq; $changed(processor_flag_word[0]) |-> $past(eq_src);
	endproperty
	a_eq: assert property (p_eq) else $error("eq moved");
	property p_ipmv; $changed(instruction_pointer) |-> $past(ip_src);
	endproperty
	a_ipmv: assert property (p_ipmv) else $error("ip moved");
	property p_ipinc;
		wr_ins && !pwdata[5] |=>
			instruction_pointer == $past(instruction_pointer) + 16'h1;
	endproperty
	a_ipinc: assert property (p_ipinc) else $error("ip step");
	property p_ins; !$rose(in_service); endproperty
	a_ins: assert property (p_ins) else $error("in service");
endmodule
bind accum_core accum_core_sva i_sva (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.instruction_pointer(instruction_pointer),
	.processor_flag_word(processor_flag_word), .in_service(in_service));
`default_nettype wire

// File: alu_if.sv
// Purpose: Carries operands and results between core and unary unit
// Assumes: One clock domain
// Notes: Purely combinational payload
`timescale 1ns/10ps
`default_nettype none
interface alu_if;
	core_pkg::op_t op;
	core_pkg::alu_in_t din;
	logic [15:0] src;
	core_pkg::alu_out_t dout;
	modport core (output op, output din, output src, input dout);
	modport unit (input op, input din, input src, output dout);
endinterface
`default_nettype wire

// File: core_defines.svh
// Purpose: Offsets, field positions, reset values and codes of the core
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef CORE_DEFINES_SVH
`define CORE_DEFINES_SVH
// ----------------------------------------------------------------
// APB map (byte addresses)
// ----------------------------------------------------------------
`define OFS_INSTR 12'h000
`define OFS_OPERAND 12'h004
`define OFS_FLAGS 12'h008
`define OFS_PTR 12'h00c
`define OFS_STEP 12'h010
`define OFS_IPTR 12'h014
`define OFS_ACC 12'h018
`define OFS_STACK 12'h01c
`define OFS_PREFIX 12'h020
`define OFS_ACCWIN 12'h040
// ----------------------------------------------------------------
// Flag word fields, reset values and codes
// ----------------------------------------------------------------
`define FLG_E 0
`define FLG_C 1
`define FLG_OV 2
`define FLG_S 6
`define FLG_Z 7
`define FLAGS_RST 8'h00
`define PTR_RST 4'h0
`define STEP_RST 8'h00
`define IP_RST 16'h0000
`define STEP_IDS 6
`define INSTR_OK 32'h0000_0001
`define INSTR_BAD 32'h0000_0002
`endif

// File: core_pkg.sv
// Purpose: Types shared by the core files
// Assumes: Nothing
// Notes: Opcode codes are fixed binary
package core_pkg;
	typedef enum logic [5:0] {
		OP_NOP = 6'b000000, OP_CPL = 6'b000001, OP_NEG = 6'b000010,
		OP_RL = 6'b000011, OP_RLC = 6'b000100, OP_RR = 6'b000101,
		OP_RRC = 6'b000110, OP_SLA = 6'b000111, OP_ARITH_SHIFT_LEFT_TWO = 6'b001000,
		OP_ARITH_SHIFT_LEFT_FOUR = 6'b001001, OP_SR = 6'b001010, OP_SRA = 6'b001011,
		OP_ARITH_SHIFT_RIGHT_TWO = 6'b001100, OP_ARITH_SHIFT_RIGHT_FOUR = 6'b001101, OP_XCHN = 6'b001110,
		OP_XCH = 6'b001111, OP_BIT2C = 6'b010000, OP_C2BIT = 6'b010001,
		OP_BAND = 6'b010010, OP_BOR = 6'b010011, OP_BXOR = 6'b010100,
		OP_SETC = 6'b010101, OP_CLRC = 6'b010110, OP_CPLC = 6'b010111,
		OP_ADD = 6'b011000, OP_ADDC = 6'b011001, OP_SUB = 6'b011010,
		OP_SUBB = 6'b011011, OP_CMP = 6'b011100, OP_WRFLAGS = 6'b011101,
		OP_JREL = 6'b100000, OP_JIMM = 6'b100001, OP_JREG16 = 6'b100010,
		OP_JREG8 = 6'b100011, OP_CALLREL = 6'b100100,
		OP_CALLIMM = 6'b100101, OP_CALLREG = 6'b100110,
		OP_RET = 6'b100111, OP_RETI = 6'b101000
	} op_t;
	typedef enum logic [2:0] {
		CND_ALWAYS = 3'b000, CND_C = 3'b001, CND_NC = 3'b010,
		CND_Z = 3'b011, CND_NZ = 3'b100, CND_S = 3'b101,
		CND_E = 3'b110, CND_NE = 3'b111
	} cond_t;
	typedef struct packed {
		logic [15:0] acc;
		logic c_in;
		logic [4:0] bsel;
	} alu_in_t;
	typedef struct packed {
		logic [15:0] res;
		logic c_out;
		logic c_wr;
		logic ov;
		logic ov_wr;
		logic acc_wr;
		logic step;
	} alu_out_t;
endpackage

// File: tb_top.sv
// Purpose: Directed self-checking bench of the accumulator core
// Assumes: Opcode and condition codes as the core package fixes them
// Notes: Opcodes written as raw six-bit codes to keep tables short
`timescale 1ns/10ps
`default_nettype none
`include "core_defines.svh"
module tb_top;
	typedef struct packed {
		logic [5:0] op; logic [3:0] b; logic ci; logic [15:0] r; logic co;
	} uop_t;
	typedef struct packed {
		logic [5:0] op; logic [2:0] c; logic [15:0] d; logic [15:0] r;
	} jmp_t;
	localparam uop_t UN [14] = '{'{6'h01,4'h0,1'b1,16'h7bde,1'b1},
		'{6'h02,4'h0,1'b1,16'h7bdf,1'b1}, '{6'h03,4'h0,1'b1,16'h0843,1'b1},
		'{6'h04,4'h0,1'b0,16'h0842,1'b1}, '{6'h05,4'h0,1'b1,16'hc210,1'b1},
		'{6'h06,4'h0,1'b0,16'h4210,1'b1}, '{6'h07,4'h0,1'b0,16'h0842,1'b1},
		'{6'h08,4'h0,1'b1,16'h1084,1'b0}, '{6'h09,4'h0,1'b1,16'h4210,1'b0},
		'{6'h0a,4'h0,1'b0,16'h4210,1'b1}, '{6'h0b,4'h0,1'b0,16'hc210,1'b1},
		'{6'h0c,4'h0,1'b1,16'he108,1'b0}, '{6'h0d,4'h0,1'b1,16'hf842,1'b0},
		'{6'h0e,4'h0,1'b1,16'h4812,1'b1}};
	localparam uop_t XC = '{6'h0f,4'h0,1'b1,16'h2184,1'b1};
	localparam uop_t BT [8] = '{'{6'h10,4'h5,1'b0,16'h0020,1'b1},
		'{6'h11,4'hf,1'b0,16'h8020,1'b1}, '{6'h12,4'h0,1'b0,16'h8020,1'b0},
		'{6'h13,4'hf,1'b0,16'h8020,1'b1}, '{6'h14,4'hf,1'b0,16'h8020,1'b0},
		'{6'h17,4'h0,1'b0,16'h8020,1'b1}, '{6'h16,4'h0,1'b0,16'h8020,1'b0},
		'{6'h15,4'h0,1'b0,16'h8020,1'b1}};
	// Flags during the jump table: C=1, E=1, S=0, Z=0
	localparam jmp_t JT [10] = '{'{6'h20,3'h0,16'h0080,16'h0081},
		'{6'h20,3'h0,16'h007f,16'h0180}, '{6'h21,3'h1,16'h2000,16'h2000},
		'{6'h21,3'h2,16'h2000,16'h0101}, '{6'h22,3'h4,16'h2222,16'h2222},
		'{6'h21,3'h5,16'h3333,16'h0101}, '{6'h21,3'h6,16'h3333,16'h3333},
		'{6'h21,3'h7,16'h3333,16'h0101}, '{6'h23,3'h0,16'h0034,16'h1234},
		'{6'h22,3'h6,16'h4444,16'h0101}};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rv;
	logic pready, pslverr, rerr, in_service;
	logic [15:0] instruction_pointer;
	logic [7:0] processor_flag_word;
	int failures = 0;
	int checked = 0;
	int cycles = 0;
	accum_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.instruction_pointer(instruction_pointer),
		.processor_flag_word(processor_flag_word), .in_service(in_service));
	always #20 pclk = ~pclk;
	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic wrap_up;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e,
		input string m);
		checked++;
		if (g !== e) begin
			failures++;
			$display("BAD %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	// Idle edge at the end keeps two tasks from driving psel in one step
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rv = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e,
		input string m);
		apb(1'b0, a, 32'h0);
		chk(rv, e, m);
	endtask
	task automatic ex(input logic [5:0] op, input logic [2:0] c,
		input logic [3:0] b, input logic [15:0] d);
		wr(`OFS_OPERAND, {16'h0, d});
		wr(`OFS_INSTR, {12'h0, b, 5'h0, c, 2'h0, op});
	endtask
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			wrap_up();
		end
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(processor_flag_word, 8'h80, "reset flags");
		rdc(12'h0fc, 32'h0, "unmapped read");
		chk(rerr, 1'b1, "unmapped error");
		$display("reset test done");
		wr(`OFS_STEP, 32'h4);
		for (int i = 0; i < 15; i++) begin
			uop_t u;
			u = (i < 14) ? UN[i] : XC;
			wr(`OFS_PTR, 32'h0);
			wr(`OFS_ACC, 32'h8421);
			wr(`OFS_FLAGS, {30'h0, u.ci, 1'b0});
			ex(u.op, 3'h0, 4'h0, 16'h0);
			rdc(`OFS_PTR, 32'h1, "auto step");
			wr(`OFS_PTR, 32'h0);
			rdc(`OFS_ACC, {16'h0, u.r}, "unary result");
			chk(processor_flag_word[`FLG_C], u.co, "unary carry");
		end
		$display("unary test done");
		wr(`OFS_PTR, 32'h0);
		wr(`OFS_ACC, 32'h20);
		wr(`OFS_FLAGS, 32'h0);
		for (int i = 0; i < 8; i++) begin
			ex(BT[i].op, 3'h0, BT[i].b, 16'h0);
			rdc(`OFS_ACC, {16'h0, BT[i].r}, "bit op acc");
			chk(processor_flag_word[`FLG_C], BT[i].co, "bit carry");
		end
		rdc(`OFS_PTR, 32'h0, "bit op no step");
		chk(processor_flag_word[`FLG_S], 1'b1, "sign mirror");
		$display("bit test done");
		wr(`OFS_STEP, 32'h0);
		wr(`OFS_FLAGS, 32'h0);
		wr(`OFS_ACC, 32'h7fff);
		ex(6'h18, 3'h0, 4'h0, 16'h0001);
		chk(processor_flag_word, 8'h44, "add flags");
		ex(6'h1c, 3'h0, 4'h0, 16'h8000);
		chk(processor_flag_word, 8'h45, "cmp equal");
		ex(6'h1a, 3'h0, 4'h0, 16'h0001);
		chk(processor_flag_word, 8'h05, "sub flags");
		ex(6'h1c, 3'h0, 4'h0, 16'h1234);
		chk(processor_flag_word, 8'h04, "cmp differ");
		wr(`OFS_FLAGS, 32'h3);
		chk(processor_flag_word, 8'h07, "flag write");
		ex(6'h1b, 3'h0, 4'h0, 16'h0000);
		chk(processor_flag_word, 8'h01, "subb flags");
		rdc(`OFS_ACC, 32'h7ffe, "subb result");
		ex(6'h1d, 3'h0, 4'h0, 16'h0007);
		chk(processor_flag_word, 8'h03, "psf write");
		$display("flag test done");
		wr(`OFS_PREFIX, 32'h12);
		for (int i = 0; i < 10; i++) begin
			wr(`OFS_IPTR, 32'h0100);
			rdc(`OFS_IPTR, 32'h0101, "ip read");
			ex(JT[i].op, JT[i].c, 4'h0, JT[i].d);
			chk(instruction_pointer, JT[i].r, "jump target");
		end
		rdc(`OFS_INSTR, `INSTR_BAD, "eq reg target");
		wr(`OFS_IPTR, 32'h0500);
		ex(6'h25, 3'h0, 4'h0, 16'h3000);
		chk(instruction_pointer, 16'h3000, "call");
		rdc(`OFS_STACK, 32'h1, "pushed");
		ex(6'h27, 3'h0, 4'h0, 16'h0);
		chk(instruction_pointer, 16'h0501, "return");
		rdc(`OFS_STACK, 32'h0, "popped");
		ex(6'h25, 3'h0, 4'h0, 16'h4000);
		ex(6'h28, 3'h0, 4'h0, 16'h0);
		chk(instruction_pointer, 16'h0502, "int return");
		chk(in_service, 1'b0, "in service");
		$display("flow test done");
		wrap_up();
	end
endmodule
`default_nettype wire
